// ---- pafs_top.sv ----
// Notes on behaviour
// - two 16-bit r/w function-select registers, upper for pins 15..8, lower for 7..0
// - power-on: upper loads 4000 in extended mode, 0000 in single chip mode
// - power-on: lower loads 0000, all pins 7..0 general io
// - only power-on reset initialises; manual, watchdog, standby, sleep keep contents
// - reserved bits read zero and ignore writes; software writes zero
// - operating mode overrides strobe, chip select and dma request selections
// - upper bit 14: pin 15 general io or system clock output
// - upper bit 12: pin 14 read strobe; single chip forces io, rom invalid forces strobe
// - upper bit 10: pin 13 upper write strobe, same mode overrides
// - upper bit 8: pin 12 lower write strobe, same mode overrides
// - upper bit 6: pin 11 chip select 1, same mode overrides
// - upper bit 4: pin 10 chip select 0, same mode overrides
// - upper bits 3:2: pin 9 io, timer clock d, interrupt 3, reserved
// - upper bits 1:0: pin 8 io, timer clock c, interrupt 2, reserved
// - lower bits 15:14: pin 7 io, timer clock b, chip select 3, reserved
// - lower bits 13:12: pin 6 io, timer clock a, chip select 2, reserved
// - lower bits 11:10: pin 5 io, serial clock 1, dma request 1, interrupt 1
// - lower bit 8: pin 4 general io or serial 1 transmit
// - lower bit 6: pin 3 general io or serial 1 receive
// - lower bits 5:4: pin 2 io, serial clock 0, dma request 0, interrupt 0
// - lower bit 2: pin 1 general io or serial 0 transmit
// - lower bit 0: pin 0 general io or serial 0 receive
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module pafs_top
  import pafs_pkg::*;
(
  input wire logic hclk,                          // bus clock
  input wire logic hresetn,                       // external power-on reset only
  input wire logic hsel,                          // slave select
  input wire logic [31:0] haddr,                  // byte address
  input wire logic [1:0] htrans,                  // transfer type
  input wire logic hwrite,                        // write not read
  input wire logic [2:0] hsize,                   // transfer size
  input wire logic hready,                        // bus ready in
  input wire logic [31:0] hwdata,                 // write data
  output logic [31:0] hrdata,                     // read data
  output logic hreadyout,                         // slave ready
  output logic hresp,                             // always okay
  input wire pafs_pkg::pafs_mode_t op_mode,       // operating mode straps
  output pafs_pkg::pafs_func_t pin_func [15:0],   // per-pin function
  output logic [15:0] upper_sel,                  // stored upper register
  output logic [15:0] lower_sel                   // stored lower register
);
  import pafs_pkg::*;

  pafs_state_t s_q;
  pafs_state_t s_d;
  logic addr_phase;
  logic [15:0] up_word;
  logic [15:0] lo_word;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // a bus strobe: single chip forces io, rom invalid forces the strobe
  function automatic pafs_func_t strobe_sel(input logic bit_v, input pafs_mode_t m, input pafs_func_t fn);
    begin
      if (m.single_chip)
        strobe_sel = PAFS_FN_GPIO;
      else if (m.rom_invalid || bit_v)
        strobe_sel = fn;
      else
        strobe_sel = PAFS_FN_GPIO;
    end
  endfunction : strobe_sel

  // two-bit field with an overridable code 10 and optional code 11
  function automatic pafs_func_t two_bit_sel(input logic [1:0] f, input pafs_mode_t m, input pafs_func_t fn01,
                                             input pafs_func_t fn10, input logic ovr10, input pafs_func_t fn11);
    begin
      unique case (f)
        2'h0: two_bit_sel = PAFS_FN_GPIO;
        2'h1: two_bit_sel = fn01;
        2'h2: two_bit_sel = (ovr10 && m.single_chip) ? PAFS_FN_GPIO : fn10;
        2'h3: two_bit_sel = fn11;
      endcase
    end
  endfunction : two_bit_sel

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  assign up_word = hwdata[15:0] & PAFS_UPPER_WMASK;
  assign lo_word = hwdata[15:0] & PAFS_LOWER_WMASK;

  always_comb
  begin
    s_d = s_q;
    // upper register reset value depends on boot mode, caught after release
    if (!s_q.init_done_q)
    begin
      s_d.init_done_q = 1'b1;
      s_d.upper_q = op_mode.single_chip ? PAFS_UPPER_RST_SC : PAFS_UPPER_RST_EXT;
    end
    // data phase of a write stores into the addressed register
    if (s_q.dp_write_q && s_q.dp_upper_q)
      s_d.upper_q = up_word;
    if (s_q.dp_write_q && s_q.dp_lower_q)
      s_d.lower_q = lo_word;
    // address phase capture
    if (hready)
    begin
      s_d.dp_write_q = addr_phase && hwrite;
      s_d.dp_upper_q = addr_phase && (haddr[7:0] == PAFS_UPPER_OFS[7:0]) && (haddr[31:8] == '0);
      s_d.dp_lower_q = addr_phase && (haddr[7:0] == PAFS_LOWER_OFS[7:0]) && (haddr[31:8] == '0);
    end
    // read data, unmapped reads zero
    s_d.rdata_q = '0;
    if (addr_phase && !hwrite)
    begin
      if (haddr == PAFS_UPPER_OFS)
        s_d.rdata_q = {16'h0000, s_d.upper_q};
      else if (haddr == PAFS_LOWER_OFS)
        s_d.rdata_q = {16'h0000, s_d.lower_q};
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // only the power-on reset reaches these flops; other resets never do
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.upper_q <= PAFS_UPPER_RST_SC;
      s_q.lower_q <= PAFS_LOWER_RST;
      s_q.dp_write_q <= 1'b0;
      s_q.dp_upper_q <= 1'b0;
      s_q.dp_lower_q <= 1'b0;
      s_q.rdata_q <= '0;
      s_q.init_done_q <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // bus outputs
  // ----------------------------------------
  assign hrdata = s_q.rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign upper_sel = s_q.upper_q;
  assign lower_sel = s_q.lower_q;

  // ----------------------------------------
  // pin function decode
  // ----------------------------------------
  // mode overrides apply to strobes, chip selects and dma requests
  always_comb
  begin
    pin_func[15] = s_q.upper_q[PAFS_P15_BIT] ? PAFS_FN_SYS_CLK_OUT : PAFS_FN_GPIO;
    pin_func[14] = strobe_sel(s_q.upper_q[PAFS_P14_BIT], op_mode, PAFS_FN_READ_STROBE);
    pin_func[13] = strobe_sel(s_q.upper_q[PAFS_P13_BIT], op_mode, PAFS_FN_WRITE_STROBE_UPPER);
    pin_func[12] = strobe_sel(s_q.upper_q[PAFS_P12_BIT], op_mode, PAFS_FN_WRITE_STROBE_LOWER);
    pin_func[11] = strobe_sel(s_q.upper_q[PAFS_P11_BIT], op_mode, PAFS_FN_CHIP_SEL);
    pin_func[10] = strobe_sel(s_q.upper_q[PAFS_P10_BIT], op_mode, PAFS_FN_CHIP_SEL);
    pin_func[9] = two_bit_sel(s_q.upper_q[PAFS_P9_LSB +: 2], op_mode, PAFS_FN_TIMER_EXT_CLK,
                              PAFS_FN_EXT_INTERRUPT, 1'b0, PAFS_FN_GPIO);
    pin_func[8] = two_bit_sel(s_q.upper_q[PAFS_P8_LSB +: 2], op_mode, PAFS_FN_TIMER_EXT_CLK,
                              PAFS_FN_EXT_INTERRUPT, 1'b0, PAFS_FN_GPIO);
    pin_func[7] = two_bit_sel(s_q.lower_q[PAFS_P7_LSB +: 2], op_mode, PAFS_FN_TIMER_EXT_CLK,
                              PAFS_FN_CHIP_SEL, 1'b1, PAFS_FN_GPIO);
    pin_func[6] = two_bit_sel(s_q.lower_q[PAFS_P6_LSB +: 2], op_mode, PAFS_FN_TIMER_EXT_CLK,
                              PAFS_FN_CHIP_SEL, 1'b1, PAFS_FN_GPIO);
    pin_func[5] = two_bit_sel(s_q.lower_q[PAFS_P5_LSB +: 2], op_mode, PAFS_FN_SERIAL_CLK,
                              PAFS_FN_DMA_REQUEST, 1'b1, PAFS_FN_EXT_INTERRUPT);
    pin_func[4] = s_q.lower_q[PAFS_P4_BIT] ? PAFS_FN_SERIAL_TX : PAFS_FN_GPIO;
    pin_func[3] = s_q.lower_q[PAFS_P3_BIT] ? PAFS_FN_SERIAL_RX : PAFS_FN_GPIO;
    pin_func[2] = two_bit_sel(s_q.lower_q[PAFS_P2_LSB +: 2], op_mode, PAFS_FN_SERIAL_CLK,
                              PAFS_FN_DMA_REQUEST, 1'b1, PAFS_FN_EXT_INTERRUPT);
    pin_func[1] = s_q.lower_q[PAFS_P1_BIT] ? PAFS_FN_SERIAL_TX : PAFS_FN_GPIO;
    pin_func[0] = s_q.lower_q[PAFS_P0_BIT] ? PAFS_FN_SERIAL_RX : PAFS_FN_GPIO;
  end

endmodule : pafs_top

`default_nettype wire

// ---- pafs_pkg.sv ----
package pafs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] PAFS_UPPER_OFS = 32'h0000_0000;
  localparam logic [31:0] PAFS_LOWER_OFS = 32'h0000_0004;

  // writable bit masks, reserved bits read zero
  localparam logic [15:0] PAFS_UPPER_WMASK = 16'h555f;
  localparam logic [15:0] PAFS_LOWER_WMASK = 16'hfd75;

  // reset values
  localparam logic [15:0] PAFS_UPPER_RST_EXT = 16'h4000;
  localparam logic [15:0] PAFS_UPPER_RST_SC = 16'h0000;
  localparam logic [15:0] PAFS_LOWER_RST = 16'h0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PAFS_P15_BIT = 14;
  localparam int PAFS_P14_BIT = 12;
  localparam int PAFS_P13_BIT = 10;
  localparam int PAFS_P12_BIT = 8;
  localparam int PAFS_P11_BIT = 6;
  localparam int PAFS_P10_BIT = 4;
  localparam int PAFS_P9_LSB = 2;
  localparam int PAFS_P8_LSB = 0;
  localparam int PAFS_P7_LSB = 14;
  localparam int PAFS_P6_LSB = 12;
  localparam int PAFS_P5_LSB = 10;
  localparam int PAFS_P4_BIT = 8;
  localparam int PAFS_P3_BIT = 6;
  localparam int PAFS_P2_LSB = 4;
  localparam int PAFS_P1_BIT = 2;
  localparam int PAFS_P0_BIT = 0;

  // ----------------------------------------
  // per-pin function codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    PAFS_FN_GPIO = 4'h0,
    PAFS_FN_SYS_CLK_OUT = 4'h1,
    PAFS_FN_READ_STROBE = 4'h2,
    PAFS_FN_WRITE_STROBE_UPPER = 4'h3,
    PAFS_FN_WRITE_STROBE_LOWER = 4'h4,
    PAFS_FN_CHIP_SEL = 4'h5,
    PAFS_FN_TIMER_EXT_CLK = 4'h6,
    PAFS_FN_EXT_INTERRUPT = 4'h7,
    PAFS_FN_DMA_REQUEST = 4'h8,
    PAFS_FN_SERIAL_CLK = 4'h9,
    PAFS_FN_SERIAL_TX = 4'ha,
    PAFS_FN_SERIAL_RX = 4'hb
  } pafs_func_t;

  // operating mode as seen by the mux
  typedef struct packed {
    logic single_chip;    // single chip mode
    logic rom_invalid;    // on-chip rom invalid mode
  } pafs_mode_t;

  // all state of the block
  typedef struct packed {
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic dp_write_q;
    logic dp_upper_q;
    logic dp_lower_q;
    logic [31:0] rdata_q;
    logic init_done_q;
  } pafs_state_t;

endpackage : pafs_pkg

// ---- pafs_strap_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// boot straps seen by the mux, held as levels
module pafs_strap_model
(
  input wire logic boot_single,            // single chip boot
  input wire logic rom_off,                // on-chip rom invalid
  output pafs_pkg::pafs_mode_t op_mode     // strap levels to block
);
  // straps are plain levels, no timing of their own
  assign op_mode = '{single_chip: boot_single, rom_invalid: rom_off};
endmodule : pafs_strap_model

`default_nettype wire

// ---- pafs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module pafs_chk
  import pafs_pkg::*;
(
  input wire logic hclk,                   // clock
  input wire logic hresetn,                // reset
  input wire logic hsel,                   // select
  input wire logic [31:0] haddr,           // address
  input wire logic [1:0] htrans,           // transfer type
  input wire logic hwrite,                 // write
  input wire logic hready,                 // ready
  input wire logic [31:0] hwdata,          // write data
  input wire logic [31:0] hrdata,          // read data
  input wire pafs_pkg::pafs_mode_t op_mode,      // mode
  input wire pafs_pkg::pafs_func_t pin_func [15:0], // functions
  input wire logic [15:0] upper_sel,       // upper register
  input wire logic [15:0] lower_sel        // lower register
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // taken address phases
  wire logic wa = hsel && hready && htrans[1] && hwrite;
  wire logic ra = hsel && hready && htrans[1] && !hwrite;
  // expected function of a mode-overridden pin
  function automatic pafs_func_t ov(logic b, pafs_func_t f, pafs_mode_t m);
    return m.single_chip ? PAFS_FN_GPIO : (b | m.rom_invalid) ? f : PAFS_FN_GPIO;
  endfunction : ov
  property p_rst;
    !$past(hresetn) |=> upper_sel == ($past(op_mode.single_chip) ? PAFS_UPPER_RST_SC : PAFS_UPPER_RST_EXT)
      && lower_sel == PAFS_LOWER_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("boot value wrong");
  property p_wr;
    wa && haddr == PAFS_UPPER_OFS ##1 1 |=> upper_sel == ($past(hwdata[15:0]) & PAFS_UPPER_WMASK);
  endproperty
  a_wr: assert property (p_wr) else $error("upper write lost");
  property p_res;
    (upper_sel & ~PAFS_UPPER_WMASK) == 16'h0000 && (lower_sel & ~PAFS_LOWER_WMASK) == 16'h0000;
  endproperty
  a_res: assert property (p_res) else $error("reserved bit set");
  property p_keep;
    $past(hresetn) && !wa ##1 1 |=> $stable(upper_sel) && $stable(lower_sel);
  endproperty
  a_keep: assert property (p_keep) else $error("register changed unasked");
  property p_rd;
    ra && haddr == PAFS_LOWER_OFS |=> hrdata == {16'h0000, lower_sel};
  endproperty
  a_rd: assert property (p_rd) else $error("lower read wrong");
  property p_p15;
    pin_func[15] == (upper_sel[14] ? PAFS_FN_SYS_CLK_OUT : PAFS_FN_GPIO);
  endproperty
  a_p15: assert property (p_p15) else $error("pin 15 wrong");
  property p_p14;
    pin_func[14] == ov(upper_sel[12], PAFS_FN_READ_STROBE, op_mode);
  endproperty
  a_p14: assert property (p_p14) else $error("pin 14 wrong");
  property p_p11;
    pin_func[11] == ov(upper_sel[6], PAFS_FN_CHIP_SEL, op_mode);
  endproperty
  a_p11: assert property (p_p11) else $error("pin 11 wrong");
  property p_p9;
    pin_func[9] == (upper_sel[3:2] == 2'b01 ? PAFS_FN_TIMER_EXT_CLK :
      upper_sel[3:2] == 2'b10 ? PAFS_FN_EXT_INTERRUPT : PAFS_FN_GPIO);
  endproperty
  a_p9: assert property (p_p9) else $error("pin 9 wrong");
  property p_p5;
    pin_func[5] == (lower_sel[11:10] == 2'b01 ? PAFS_FN_SERIAL_CLK : lower_sel[11:10] == 2'b11 ?
      PAFS_FN_EXT_INTERRUPT : (lower_sel[11] && !op_mode.single_chip) ? PAFS_FN_DMA_REQUEST : PAFS_FN_GPIO);
  endproperty
  a_p5: assert property (p_p5) else $error("pin 5 wrong");
endmodule : pafs_chk

bind pafs_top pafs_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
  .op_mode, .pin_func, .upper_sel, .lower_sel);

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pafs_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sc = 0, ri = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, lv;
  logic [1:0] htrans = 0, cb;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hready, hresp;
  wire pafs_mode_t op_mode;
  pafs_func_t pin_func [15:0];
  logic [15:0] upper_sel, lower_sel;
  int err_count = 0, compares = 0;
  // clock at 100 MHz
  initial forever #5 hclk = ~hclk;
  pafs_strap_model u_strap (.boot_single(sc), .rom_off(ri), .op_mode(op_mode));
  pafs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .op_mode(op_mode), .pin_func(pin_func), .upper_sel(upper_sel), .lower_sel(lower_sel));
  task wrap_up;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one single ahb transfer, entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hready}, 32'h1);
  endtask : rdc
  task pf(input int n, input pafs_func_t f);
    chk({28'h0, pin_func[n]}, {28'h0, f});
  endtask : pf
  function automatic pafs_func_t tab(logic [1:0] c, pafs_func_t a, pafs_func_t b, pafs_func_t d);
    return c == 2'b01 ? a : c == 2'b10 ? b : c == 2'b11 ? d : PAFS_FN_GPIO;
  endfunction : tab
  // watchdog on a hung run
  initial
  begin
    #50000;
    err_count++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(PAFS_UPPER_OFS, 32'h4000);
    rdc(PAFS_LOWER_OFS, 32'h0);
    pf(15, PAFS_FN_SYS_CLK_OUT);
    xfer(1'b1, PAFS_UPPER_OFS, 32'hffff);
    rdc(PAFS_UPPER_OFS, 32'h555f);
    xfer(1'b1, PAFS_LOWER_OFS, 32'hffff);
    rdc(PAFS_LOWER_OFS, 32'hfd75);
    xfer(1'b1, 32'h8, 32'hffff);
    rdc(32'h8, 32'h0);
    rdc(PAFS_UPPER_OFS, 32'h555f);
    // strobes and chip selects under normal, rom invalid and single chip
    for (int m = 0; m < 3; m++)
      for (int v = 0; v < 2; v++)
      begin
        sc <= (m == 2);
        ri <= (m == 1);
        xfer(1'b1, PAFS_UPPER_OFS, v ? 32'h1550 : 32'h0);
        rdc(PAFS_UPPER_OFS, v ? 32'h1550 : 32'h0);
        pf(14, (m == 2 || m + v == 0) ? PAFS_FN_GPIO : PAFS_FN_READ_STROBE);
        pf(13, (m == 2 || m + v == 0) ? PAFS_FN_GPIO : PAFS_FN_WRITE_STROBE_UPPER);
        pf(12, (m == 2 || m + v == 0) ? PAFS_FN_GPIO : PAFS_FN_WRITE_STROBE_LOWER);
        pf(11, (m == 2 || m + v == 0) ? PAFS_FN_GPIO : PAFS_FN_CHIP_SEL);
        pf(10, (m == 2 || m + v == 0) ? PAFS_FN_GPIO : PAFS_FN_CHIP_SEL);
      end
    // every code of the pin 9..0 fields, normal then single chip
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        sc <= m[0];
        ri <= 1'b0;
        cb = c[1:0];
        lv = {16'h0, cb, cb, cb, 1'b0, cb[0], 1'b0, cb[0], cb, 1'b0, cb[0], 1'b0, cb[0]};
        xfer(1'b1, PAFS_UPPER_OFS, {28'h0, cb, cb});
        xfer(1'b1, PAFS_LOWER_OFS, lv);
        rdc(PAFS_LOWER_OFS, lv);
        pf(9, tab(cb, PAFS_FN_TIMER_EXT_CLK, PAFS_FN_EXT_INTERRUPT, PAFS_FN_GPIO));
        pf(8, tab(cb, PAFS_FN_TIMER_EXT_CLK, PAFS_FN_EXT_INTERRUPT, PAFS_FN_GPIO));
        pf(7, tab(cb, PAFS_FN_TIMER_EXT_CLK, m ? PAFS_FN_GPIO : PAFS_FN_CHIP_SEL, PAFS_FN_GPIO));
        pf(6, tab(cb, PAFS_FN_TIMER_EXT_CLK, m ? PAFS_FN_GPIO : PAFS_FN_CHIP_SEL, PAFS_FN_GPIO));
        pf(5, tab(cb, PAFS_FN_SERIAL_CLK, m ? PAFS_FN_GPIO : PAFS_FN_DMA_REQUEST, PAFS_FN_EXT_INTERRUPT));
        pf(2, tab(cb, PAFS_FN_SERIAL_CLK, m ? PAFS_FN_GPIO : PAFS_FN_DMA_REQUEST, PAFS_FN_EXT_INTERRUPT));
        pf(4, cb[0] ? PAFS_FN_SERIAL_TX : PAFS_FN_GPIO);
        pf(3, cb[0] ? PAFS_FN_SERIAL_RX : PAFS_FN_GPIO);
        pf(1, cb[0] ? PAFS_FN_SERIAL_TX : PAFS_FN_GPIO);
        pf(0, cb[0] ? PAFS_FN_SERIAL_RX : PAFS_FN_GPIO);
      end
    // second power-on reset, now booting single chip
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(PAFS_UPPER_OFS, 32'h0);
    rdc(PAFS_LOWER_OFS, 32'h0);
    pf(15, PAFS_FN_GPIO);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
